//--- include/fph_params.svh
/*
 Opcodes and timing constants of the flash power, hold and abort logic.
 Assumes a 100 MHz ref_clk_i; counts derive from the ns figures below.
*/
`ifndef FPH_PARAMS_SVH
`define FPH_PARAMS_SVH

`define FPH_OP_DEEP_ENTER 8'hB9
`define FPH_OP_DEEP_RESUME 8'hAB
`define FPH_OP_ULTRA_ENTER 8'h79
`define FPH_OP_ABORT 8'hF0
`define FPH_OP_ABORT_CONFIRM 8'hD0
`define FPH_OP_STATUS2_WRITE 8'h31

`define FPH_CLK_MHZ 100
// longest times round down, least times round up, never below one cycle
`define FPH_CYC_DN(ns) ((((ns) * `FPH_CLK_MHZ) / 1000) < 1 ? 1 : (((ns) * `FPH_CLK_MHZ) / 1000))
`define FPH_CYC_UP(ns) ((((ns) * `FPH_CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `FPH_CLK_MHZ + 999) / 1000))

`define FPH_DEEP_SLEEP_ENTRY_TIME_NS 3000
`define FPH_DEEP_SLEEP_RESUME_TIME_NS 8000
`define FPH_ULTRA_SLEEP_ENTRY_TIME_NS 3000
`define FPH_ULTRA_SLEEP_EXIT_TIME_NS 70000
`define FPH_WAKE_PULSE_MIN_TIME_NS 20
`define FPH_CS_HIGH_MIN_TIME_NS 35

// synchroniser reset levels: {wp_n, cs_n, sck, si, hold_n}
`define FPH_PIN_RESET 5'h1B
`define FPH_SCK_HALF_CYC 8

`endif

//--- include/fph_pkg.sv
/*
 Types shared by both ends of the flash power, hold and abort link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package fph_pkg;

    typedef enum logic [2:0] {
        FPH_STANDBY = 3'h0,
        FPH_DEEP_ENT = 3'h1,
        FPH_DEEP = 3'h3,
        FPH_DEEP_RES = 3'h2,
        FPH_ULTRA_ENT = 3'h6,
        FPH_ULTRA = 3'h7,
        FPH_ULTRA_EXIT = 3'h5
    } fph_state_e;

    typedef enum logic [1:0] {
        FPH_H_IDLE = 2'h0,
        FPH_H_LEAD = 2'h1,
        FPH_H_SHIFT = 2'h3,
        FPH_H_TRAIL = 2'h2
    } fph_hstate_e;

endpackage

//--- include/fph_if.sv
/*
 Serial flash pin bundle between the host controller and the flash end.
 Assumes the bench resolves the serial output wire from so and so_oe.
*/
`timescale 1ns/1ns
`default_nettype none
interface fph_if;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic so;
    logic so_oe;

    modport flash (input cs_n, input sck, input si, input hold_n, input wp_n, output so, output so_oe);
    modport host (output cs_n, output sck, output si, output hold_n, output wp_n, input so, input so_oe);
endinterface
`default_nettype wire

//--- src/fph_flash.sv
/*
 Flash end: power states, hold pause and confirmed abort on the serial link.
 Assumes pins asynchronous to ref_clk_i and sck far slower than ref_clk_i.
*/
// Summary of operation
// - standby when deselected, no internal job and no sleep or transition state
// - deep sleep ignores all but resume opcode
// - opcode B9h enters deep sleep after deselect
// - partial or misaligned deep entry stays standby
// - deep entry ignored while program/erase runs
// - opcode ABh returns deep sleep to standby
// - partial or misaligned resume stays asleep
// - ultra sleep ignores every command
// - opcode 79h enters ultra sleep after deselect
// - partial ultra entry or busy stays standby
// - long select pulse wakes ultra sleep
// - frame during ultra exit time ignored
// - long select before first bit also wakes
// - power cycle restores defaults and standby
// - hold never stops internal program or erase
// - pause starts in clock low, selected only
// - pause floats output, ignores input and clock
// - pause ends at clock low phase
// - deselect during hold aborts, clears latch
// - abort needs permit bit, not write latch
// - F0h then D0h stops program or erase
// - abort keeps config, clears latch unless sequential
// - abort needs both bytes, byte-aligned deselect
`timescale 1ns/1ns
`default_nettype none
`include "fph_params.svh"
module fph_flash import fph_pkg::*; #(
    parameter int unsigned DEEP_ENTRY_CYC = `FPH_CYC_DN(`FPH_DEEP_SLEEP_ENTRY_TIME_NS),
    parameter int unsigned DEEP_RESUME_CYC = `FPH_CYC_DN(`FPH_DEEP_SLEEP_RESUME_TIME_NS),
    parameter int unsigned ULTRA_ENTRY_CYC = `FPH_CYC_DN(`FPH_ULTRA_SLEEP_ENTRY_TIME_NS),
    parameter int unsigned ULTRA_EXIT_CYC = `FPH_CYC_DN(`FPH_ULTRA_SLEEP_EXIT_TIME_NS),
    parameter int unsigned WAKE_MIN_CYC = `FPH_CYC_UP(`FPH_WAKE_PULSE_MIN_TIME_NS)
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial link
    fph_if.flash spi,
    // array core side
    input wire logic busy_i,
    input wire logic seq_prog_i,
    input wire logic abort_permit_bit_i,
    input wire logic so_bit_i,
    input wire logic so_en_i,
    // status and events
    output logic [2:0] mode_o,
    output logic standby_o,
    output logic paused_o,
    output logic wp_n_o,
    output logic abort_o,
    output logic op_abort_o,
    output logic write_enable_latch_clr_o,
    output logic cmd_done_o,
    output logic [7:0] cmd_op_o,
    output logic [7:0] cmd_arg_o,
    output logic [1:0] cmd_bytes_o,
    output logic cmd_aligned_o
);
    localparam int PINS = 5;

    fph_state_e state_q, state_d;
    logic [PINS-1:0] pin_raw, s1_q, s2_q, s3_q, filt_q, prev_q;
    logic [15:0] tmr_q, tmr_d, low_cnt_q;
    logic [7:0] sh_q, op_q, arg_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] nbytes_q;
    logic pause_q, ign_q, so_q;
    logic abort_d, op_abort_d, wel_clr_d, cmd_d;

    assign pin_raw = {spi.wp_n, spi.cs_n, spi.sck, spi.si, spi.hold_n};

    // three-stage synchroniser, change accepted when stages two and three agree
    for (genvar i = 0; i < PINS; i++) begin : g_sync
        always_ff @(posedge ref_clk_i) begin
            s1_q[i] <= pin_raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (rst_i) begin
                filt_q[i] <= 1'(`FPH_PIN_RESET >> i);
                prev_q[i] <= 1'(`FPH_PIN_RESET >> i);
            end else begin
                if (s2_q[i] == s3_q[i]) filt_q[i] <= s3_q[i];
                prev_q[i] <= filt_q[i];
            end
        end
    end

    wire wp_f = filt_q[4];
    wire cs_f = filt_q[3];
    wire sck_f = filt_q[2];
    wire si_f = filt_q[1];
    wire hold_f = filt_q[0];
    wire cs_fall = prev_q[3] & ~cs_f;
    wire cs_rise = ~prev_q[3] & cs_f;
    wire sck_rise = ~prev_q[2] & sck_f & ~cs_f;
    wire shift_en = sck_rise & ~pause_q;
    wire byte_end = shift_en & (bit_cnt_q == 3'h7);
    wire [7:0] sh_next = {sh_q[6:0], si_f};
    wire aligned = bit_cnt_q == 3'h0;
    wire has_op = nbytes_q != 2'h0;
    wire has_arg = nbytes_q == 2'h2;
    wire tmr_done = tmr_q == 16'h0;
    wire start_busy_frame = (state_q == FPH_ULTRA_EXIT) | (state_q == FPH_DEEP_ENT) |
                            (state_q == FPH_DEEP_RES) | (state_q == FPH_ULTRA_ENT);
    wire abort_ok = (arg_q == `FPH_OP_ABORT_CONFIRM) & has_arg & aligned & abort_permit_bit_i;

    // pause follows hold only while the clock is low; deselect ends it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i | cs_f) pause_q <= 1'b0;
        else if (~sck_f) pause_q <= ~hold_f;
    end

    // frame capture: bit count, first two bytes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i | cs_fall) begin
            bit_cnt_q <= 3'h0;
            nbytes_q <= 2'h0;
            sh_q <= 8'h00;
        end else if (shift_en) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            sh_q <= sh_next;
            if (byte_end && nbytes_q != 2'h2) nbytes_q <= nbytes_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            op_q <= 8'h00;
            arg_q <= 8'h00;
        end else if (cs_fall) begin
            op_q <= 8'h00;
            arg_q <= 8'h00;
        end else if (byte_end) begin
            if (nbytes_q == 2'h0) op_q <= sh_next;
            if (nbytes_q == 2'h1) arg_q <= sh_next;
        end
    end

    // frames opened while a transition runs are discarded
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) ign_q <= 1'b0;
        else if (cs_fall) ign_q <= start_busy_frame;
        else if (state_q == FPH_ULTRA && shift_en) ign_q <= 1'b1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i | cs_f) low_cnt_q <= 16'h0;
        else if (low_cnt_q != 16'hFFFF) low_cnt_q <= low_cnt_q + 16'h1;
    end

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_done ? 16'h0 : tmr_q - 16'h1;
        abort_d = 1'b0;
        op_abort_d = 1'b0;
        wel_clr_d = 1'b0;
        cmd_d = 1'b0;
        case (state_q)
            FPH_STANDBY: begin
                if (cs_rise && pause_q) begin
                    op_abort_d = 1'b1;
                    wel_clr_d = 1'b1;
                end else if (cs_rise && !ign_q && has_op) begin
                    case (op_q)
                        `FPH_OP_DEEP_ENTER: begin
                            if (aligned && !busy_i) begin
                                state_d = FPH_DEEP_ENT;
                                tmr_d = 16'(DEEP_ENTRY_CYC);
                            end
                        end
                        `FPH_OP_ULTRA_ENTER: begin
                            if (!busy_i) begin
                                state_d = FPH_ULTRA_ENT;
                                tmr_d = 16'(ULTRA_ENTRY_CYC);
                            end
                        end
                        `FPH_OP_ABORT: begin
                            abort_d = abort_ok;
                            wel_clr_d = abort_ok & ~seq_prog_i;
                        end
                        default: cmd_d = 1'b1;
                    endcase
                end
            end
            FPH_DEEP_ENT: if (tmr_done) state_d = FPH_DEEP;
            FPH_DEEP: begin
                if (cs_rise && !ign_q && !pause_q && has_op && aligned && op_q == `FPH_OP_DEEP_RESUME) begin
                    state_d = FPH_DEEP_RES;
                    tmr_d = 16'(DEEP_RESUME_CYC);
                end
            end
            FPH_DEEP_RES: if (tmr_done) state_d = FPH_STANDBY;
            FPH_ULTRA_ENT: if (tmr_done) state_d = FPH_ULTRA;
            FPH_ULTRA: begin
                if (!cs_f && low_cnt_q >= 16'(ULTRA_EXIT_CYC)) begin
                    state_d = FPH_STANDBY;
                end else if (cs_rise && low_cnt_q >= 16'(WAKE_MIN_CYC)) begin
                    state_d = FPH_ULTRA_EXIT;
                    tmr_d = 16'(ULTRA_EXIT_CYC);
                end
            end
            FPH_ULTRA_EXIT: if (tmr_done) state_d = FPH_STANDBY;
            default: state_d = FPH_STANDBY;
        endcase
    end

    // reset stands for a power cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= FPH_STANDBY;
            tmr_q <= 16'h0;
            abort_o <= 1'b0;
            op_abort_o <= 1'b0;
            write_enable_latch_clr_o <= 1'b0;
            cmd_done_o <= 1'b0;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            abort_o <= abort_d;
            op_abort_o <= op_abort_d;
            write_enable_latch_clr_o <= wel_clr_d;
            cmd_done_o <= cmd_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmd_op_o <= 8'h00;
            cmd_arg_o <= 8'h00;
            cmd_bytes_o <= 2'h0;
            cmd_aligned_o <= 1'b0;
            so_q <= 1'b0;
        end else begin
            if (cmd_d) begin
                cmd_op_o <= op_q;
                cmd_arg_o <= arg_q;
                cmd_bytes_o <= nbytes_q;
                cmd_aligned_o <= aligned;
            end
            so_q <= so_bit_i;
        end
    end

    assign mode_o = state_q;
    assign standby_o = (state_q == FPH_STANDBY) & cs_f & ~busy_i;
    assign paused_o = pause_q;
    assign wp_n_o = wp_f;
    assign spi.so = so_q;
    assign spi.so_oe = so_en_i & ~cs_f & ~pause_q & (state_q == FPH_STANDBY);
endmodule
`default_nettype wire

//--- src/fph_host.sv
/*
 Host end: frames up to 16 bits on the serial link with a divided clock.
 Assumes the user waits out entry, resume, exit and abort times itself.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fph_params.svh"
module fph_host import fph_pkg::*; #(
    parameter int unsigned HALF_CYC = `FPH_SCK_HALF_CYC,
    parameter int unsigned GAP_CYC = `FPH_CYC_UP(`FPH_CS_HIGH_MIN_TIME_NS)
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial link
    fph_if.host spi,
    // user request
    input wire logic start_i,
    input wire logic [4:0] nbits_i,
    input wire logic [15:0] data_i,
    input wire logic [15:0] lead_i,
    input wire logic hold_i,
    input wire logic wp_n_i,
    // user answer
    output logic busy_o,
    output logic [15:0] rx_o
);
    fph_hstate_e st_q;
    logic [15:0] cnt_q, sh_q;
    logic [4:0] bits_q;
    logic cs_n_q, sck_q, si_q, hold_n_q;

    wire cnt_zero = cnt_q == 16'h0;
    // clock stays low one cycle past hold release, so the far end ends its pause first
    wire stall = (hold_i | ~hold_n_q) & ~sck_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q <= FPH_H_IDLE;
            cnt_q <= 16'h0;
            sh_q <= 16'h0;
            bits_q <= 5'h0;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            si_q <= 1'b0;
            rx_o <= 16'h0;
        end else begin
            case (st_q)
                FPH_H_IDLE: begin
                    if (start_i) begin
                        st_q <= FPH_H_LEAD;
                        cs_n_q <= 1'b0;
                        sh_q <= data_i;
                        si_q <= data_i[15];
                        bits_q <= nbits_i;
                        cnt_q <= lead_i;
                    end
                end
                FPH_H_LEAD: begin
                    if (!cnt_zero) cnt_q <= cnt_q - 16'h1;
                    else if (bits_q == 5'h0) begin
                        st_q <= FPH_H_TRAIL;
                        cs_n_q <= 1'b1;
                        cnt_q <= 16'(GAP_CYC);
                    end else begin
                        st_q <= FPH_H_SHIFT;
                        cnt_q <= 16'(HALF_CYC - 1);
                    end
                end
                FPH_H_SHIFT: begin
                    if (stall) cnt_q <= cnt_q;
                    else if (!cnt_zero) cnt_q <= cnt_q - 16'h1;
                    else begin
                        cnt_q <= 16'(HALF_CYC - 1);
                        sck_q <= ~sck_q;
                        if (!sck_q) rx_o <= {rx_o[14:0], spi.so};
                        else begin
                            sh_q <= {sh_q[14:0], 1'b0};
                            si_q <= sh_q[14];
                            bits_q <= bits_q - 5'h1;
                            // any bit count, deselect after the last bit
                            if (bits_q == 5'h1) begin
                                st_q <= FPH_H_TRAIL;
                                cs_n_q <= 1'b1;
                                cnt_q <= 16'(GAP_CYC);
                            end
                        end
                    end
                end
                FPH_H_TRAIL: begin
                    if (!cnt_zero) cnt_q <= cnt_q - 16'h1;
                    else st_q <= FPH_H_IDLE;
                end
                default: st_q <= FPH_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) hold_n_q <= 1'b1;
        else hold_n_q <= ~hold_i;
    end

    assign busy_o = st_q != FPH_H_IDLE;
    assign spi.cs_n = cs_n_q;
    assign spi.sck = sck_q;
    assign spi.si = si_q;
    assign spi.hold_n = hold_n_q;
    assign spi.wp_n = wp_n_i;
endmodule
`default_nettype wire

//--- tb/fph_link_props.sv
/*
 Pin-level checks on the serial link between the host and flash ends.
 Assumes the bench instantiates it beside the shared interface.
*/
`timescale 1ns/1ns
`default_nettype none
module fph_link_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so_oe
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // selected, held and clock low long enough to settle the pause
    sequence s_paused;
        (!cs_n && !hold_n && !sck) [*8];
    endsequence
    sequence s_high_phase;
        sck [*8] ##1 !sck;
    endsequence
    sequence s_hold_low;
        (!cs_n && !hold_n && !sck) ##1 !hold_n;
    endsequence

    a_pause_floats_out: assert property (s_paused |-> !so_oe)
        else $error("serial output driven during pause");
    a_idle_floats_out: assert property (cs_n [*8] |-> !so_oe)
        else $error("serial output driven while deselected");
    a_hold_freezes_sck: assert property (s_hold_low |-> !sck)
        else $error("serial clock moved during hold");
    a_si_stable_high: assert property (sck ##1 sck |-> $stable(si))
        else $error("serial input changed in clock high phase");
    a_sck_high_width: assert property ($rose(sck) |-> s_high_phase)
        else $error("serial clock high phase not eight cycles");
    a_sck_in_frame: assert property (sck |-> !cs_n)
        else $error("serial clock high while deselected");
    a_cs_lead_low: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("serial clock rose too soon after select");
    a_cs_gap_high: assert property ($rose(cs_n) |-> cs_n [*4])
        else $error("select gap shorter than four cycles");
endmodule
`default_nettype wire

//--- tb/flash_power_hold_reset_ctrl_bench.sv
/*
 Bench joining host and flash ends across the serial interface.
 Assumes shortened entry, resume and exit counts set below.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_power_hold_reset_ctrl_bench import fph_pkg::*;;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic hold = 1'b0;
    logic wp = 1'b1;
    logic busy_in = 1'b0;
    logic seq = 1'b0;
    logic permit = 1'b0;
    logic sob = 1'b1;
    logic soe = 1'b1;
    logic calign;
    logic [15:0] rx;
    logic [4:0] nbits = 5'h00;
    logic [15:0] data = 16'h0000;
    logic [15:0] lead = 16'h0000;
    logic hbusy, standby, paused, wpo, abort, opab, welc, done;
    logic [2:0] mode;
    logic [7:0] cop, carg;
    logic [1:0] cbytes;
    logic [3:0] seen = 4'h0;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    // abort cases: {permit, sequential}, bits, data, expected {abort, op abort, latch clear, done}
    logic [1:0] ab_ps [6] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3};
    logic [4:0] ab_n [6] = '{5'h10, 5'h08, 5'h0C, 5'h10, 5'h10, 5'h10};
    logic [15:0] ab_d [6] = '{16'hF0D0, 16'hF000, 16'hF0D0, 16'hF0D1, 16'hF0D0, 16'hF0D0};
    logic [3:0] ab_e [6] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hA, 4'h8};

    fph_if link ();
    fph_host fph_host_inst (.ref_clk_i(clk), .rst_i(rst), .spi(link.host), .start_i(start), .nbits_i(nbits),
        .data_i(data), .lead_i(lead), .hold_i(hold), .wp_n_i(wp), .busy_o(hbusy), .rx_o(rx));
    fph_flash #(.DEEP_ENTRY_CYC(20), .DEEP_RESUME_CYC(20), .ULTRA_ENTRY_CYC(20), .ULTRA_EXIT_CYC(50))
        fph_flash_inst (.ref_clk_i(clk), .rst_i(rst), .spi(link.flash), .busy_i(busy_in), .seq_prog_i(seq),
        .abort_permit_bit_i(permit), .so_bit_i(sob), .so_en_i(soe), .mode_o(mode), .standby_o(standby),
        .paused_o(paused), .wp_n_o(wpo), .abort_o(abort), .op_abort_o(opab), .write_enable_latch_clr_o(welc),
        .cmd_done_o(done), .cmd_op_o(cop), .cmd_arg_o(carg), .cmd_bytes_o(cbytes), .cmd_aligned_o(calign));
    fph_link_props fph_link_props_inst (.ref_clk_i(clk), .rst_i(rst), .cs_n(link.cs_n), .sck(link.sck),
        .si(link.si), .hold_n(link.hold_n), .so_oe(link.so_oe));

    initial begin
        forever #5 clk = ~clk;
    end

    // one-cycle event pulses kept until the next frame starts
    always @(posedge clk) begin
        seen <= start ? 4'h0 : (seen | {abort, opab, welc, done});
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
        check_count++;
        if (seen_v !== exp_v) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask

    task automatic cmode(input fph_state_e e);
        check(16'(mode), 16'(e));
    endtask

    task automatic go(input logic [4:0] n, input logic [15:0] d);
        @(negedge clk);
        nbits = n;
        data = d;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask

    task automatic wait_idle();
        int k = 0;
        while (hbusy !== 1'b0 && k < 1000) begin
            @(negedge clk);
            k++;
        end
        repeat (8) @(negedge clk);
    endtask

    task automatic frame(input logic [4:0] n, input logic [15:0] d, input int w);
        go(n, d);
        wait_idle();
        repeat (w) @(negedge clk);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        cmode(FPH_STANDBY);
        check(16'(standby), 16'h0001);
        frame(5'h08, 16'h0500, 0);
        check(16'(seen), 16'h0001);
        check(16'(cop), 16'h0005);
        check(16'(calign), 16'h0001);
        busy_in = 1'b1;
        repeat (6) @(negedge clk);
        check(16'(standby), 16'h0000);
        frame(5'h08, 16'hB900, 30);
        cmode(FPH_STANDBY);
        frame(5'h08, 16'h7900, 30);
        cmode(FPH_STANDBY);
        busy_in = 1'b0;
        frame(5'h07, 16'hB900, 30);
        cmode(FPH_STANDBY);
        frame(5'h0C, 16'hB900, 30);
        cmode(FPH_STANDBY);
        frame(5'h10, 16'hB9A5, 0);
        cmode(FPH_DEEP_ENT);
        repeat (30) @(negedge clk);
        cmode(FPH_DEEP);
        frame(5'h08, 16'h0500, 30);
        check(16'(seen), 16'h0000);
        frame(5'h07, 16'hAB00, 30);
        cmode(FPH_DEEP);
        frame(5'h0C, 16'hABF0, 30);
        cmode(FPH_DEEP);
        frame(5'h10, 16'hAB5A, 0);
        cmode(FPH_DEEP_RES);
        repeat (30) @(negedge clk);
        cmode(FPH_STANDBY);
        frame(5'h04, 16'h7900, 30);
        cmode(FPH_STANDBY);
        frame(5'h08, 16'h7900, 0);
        cmode(FPH_ULTRA_ENT);
        repeat (30) @(negedge clk);
        cmode(FPH_ULTRA);
        frame(5'h08, 16'hAB00, 30);
        check(16'(seen), 16'h0000);
        cmode(FPH_STANDBY);
        frame(5'h0B, 16'h7900, 30);
        cmode(FPH_ULTRA);
        lead = 16'h0004;
        frame(5'h00, 16'h0000, 0);
        lead = 16'h0000;
        cmode(FPH_ULTRA_EXIT);
        frame(5'h08, 16'h0500, 60);
        check(16'(seen), 16'h0000);
        cmode(FPH_STANDBY);
        lead = 16'h0028;
        go(5'h00, 16'h0000);
        repeat (5) @(negedge clk);
        hold = 1'b1;
        wait_idle();
        check(16'(seen), 16'h0006);
        hold = 1'b0;
        lead = 16'h0000;
        busy_in = 1'b1;
        for (int i = 0; i < 6; i++) begin
            permit = ab_ps[i][1];
            seq = ab_ps[i][0];
            frame(ab_n[i], ab_d[i], 0);
            check(16'(seen), 16'(ab_e[i]));
            cmode(FPH_STANDBY);
        end
        busy_in = 1'b0;
        seq = 1'b0;
        sob = 1'b0;
        go(5'h10, 16'h06C3);
        repeat (40) @(negedge clk);
        hold = 1'b1;
        repeat (40) @(negedge clk);
        check(16'(paused), 16'h0001);
        check(16'(link.so_oe), 16'h0000);
        wp = 1'b0;
        repeat (8) @(negedge clk);
        check(16'(wpo), 16'h0000);
        hold = 1'b0;
        wp = 1'b1;
        repeat (8) @(negedge clk);
        check(16'(paused), 16'h0000);
        check(16'(link.so_oe), 16'h0001);
        wait_idle();
        check(16'(seen), 16'h0001);
        check({cop, carg}, 16'h06C3);
        check(16'(cbytes), 16'h0002);
        check(rx, 16'h0000);
        check(16'(calign), 16'h0001);
        hold = 1'b1;
        repeat (8) @(negedge clk);
        check(16'(paused), 16'h0000);
        hold = 1'b0;
        frame(5'h08, 16'h7900, 30);
        cmode(FPH_ULTRA);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        cmode(FPH_STANDBY);
        check(16'(cop), 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
